// [bench/flash_protect_assertions.sv]
`timescale 1ns/1ps
module flash_protect_checker
  import flash_protect_pkg::*;
#(
  parameter int unsigned SECTOR_CYCLES = 20,
  parameter int unsigned BLOCK_CYCLES = 40,
  parameter int unsigned CHIP_CYCLES = 60
) (
  input wire logic core_clk_in, // core clock
  input wire logic rst_n_in, // async reset
  input wire logic link_clk_in, // link clock
  input wire logic lnk_cmd_valid_in, // command offered
  input wire link_cmd_s lnk_cmd_in, // command word
  input wire logic lnk_cmd_ready_out, // command can be taken
  input wire logic [23:0] lnk_status_out, // link side status
  input wire logic wp_n_in, // write-protect pin
  input wire logic [23:0] status_out, // core side status
  input wire logic array_req_out, // start pulse
  input wire array_req_s array_op_out, // started operation
  input wire logic cmd_reject_out // refusal pulse
);
  // a command either starts or is refused, never both
  a_pulse_excl: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !(array_req_out && cmd_reject_out)) else $error("start and refusal together");
  a_start_latched: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    array_req_out |-> status_out[BUSY_BIT] && status_out[LATCH_BIT])
    else $error("start without busy and latch");
  a_start_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    array_req_out |-> !$past(status_out[BUSY_BIT])) else $error("start while busy");
  a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_out[20:18] == 3'h0) else $error("reserved status bits set");
  a_latch_end: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(status_out[BUSY_BIT]) && !status_out[PROG_PAUSE_BIT] && !status_out[ERASE_PAUSE_BIT]
    |-> !status_out[LATCH_BIT]) else $error("latch kept after completion");
  a_region_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !$stable(status_out[6:2]) |-> status_out[BUSY_BIT]) else $error("region moved by no write");
  a_reject_keeps: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_reject_out |-> $stable(status_out[23:2])) else $error("refusal changed status");
  a_chip_guard: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    array_req_out && array_op_out.op == CMD_CHIP_CLEAR |->
    (status_out[4:2] == 3'h0 && !status_out[INVERT_BIT])
    || (status_out[4:2] == 3'h7 && status_out[INVERT_BIT])) else $error("chip erase in region");
  a_busy_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(status_out[BUSY_BIT]) |=> status_out[BUSY_BIT] [*8]) else $error("busy too short");
  a_pin_lock: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    status_out[MODE_LO_BIT] && !status_out[MODE_HI_BIT] && !wp_n_in && !$past(wp_n_in, 1)
    && !$past(wp_n_in, 2) && !$past(wp_n_in, 3) |=> $stable(status_out[7:2]))
    else $error("status written under pin lock");
  a_ready_drop: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
    lnk_cmd_valid_in && lnk_cmd_ready_out |=> !lnk_cmd_ready_out) else $error("ready held");
  // main scenarios reached
  c_start: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) array_req_out);
  c_reject: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) cmd_reject_out);
  c_chip: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    array_req_out && array_op_out.op == CMD_CHIP_CLEAR);
endmodule : flash_protect_checker

bind flash_status_and_array_protect flash_protect_checker #(.SECTOR_CYCLES(SECTOR_CYCLES),
  .BLOCK_CYCLES(BLOCK_CYCLES), .CHIP_CYCLES(CHIP_CYCLES)) chk_u (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
  .lnk_cmd_valid_in(lnk_cmd_valid_in), .lnk_cmd_in(lnk_cmd_in),
  .lnk_cmd_ready_out(lnk_cmd_ready_out), .lnk_status_out(lnk_status_out),
  .wp_n_in(wp_n_in), .status_out(status_out), .array_req_out(array_req_out),
  .array_op_out(array_op_out), .cmd_reject_out(cmd_reject_out));

// [bench/link_host.sv]
`timescale 1ns/1ps
module link_host
  import flash_protect_pkg::*;
(
  input wire logic link_clk_in, // controller clock
  input wire logic lnk_cmd_ready_in, // device can take a command
  output logic lnk_cmd_valid_out, // command offered
  output link_cmd_s lnk_cmd_out // command word
);
  logic rdy_s;
  initial begin
    lnk_cmd_valid_out = 1'b0;
    lnk_cmd_out = '0;
  end
  // ready moves on rising edges only, so the fall shows its value at the next rise
  always @(negedge link_clk_in) rdy_s <= lnk_cmd_ready_in;
  // offer one command, hold it until taken, then scramble the released word
  task automatic send(input link_cmd_s c);
    @(posedge link_clk_in);
    #1;
    lnk_cmd_valid_out = 1'b1;
    lnk_cmd_out = c;
    do @(posedge link_clk_in); while (rdy_s !== 1'b1);
    #1;
    lnk_cmd_valid_out = 1'b0;
    lnk_cmd_out = ~c;
  endtask : send
endmodule : link_host

// [bench/test_flash_status_and_array_protect.sv]
`timescale 1ns/1ps
module test_flash_status_and_array_protect;
  import flash_protect_pkg::*;
  logic core_clk_in, link_clk_in, rst_n_in, wp_n_in, lnk_cmd_valid_in;
  logic lnk_cmd_ready_out, array_req_out, cmd_reject_out;
  link_cmd_s lnk_cmd_in;
  array_req_s array_op_out;
  logic [23:0] lnk_status_out, status_out;
  int failures, compares, n_req, n_rej;
  flash_status_and_array_protect #(.SECTOR_CYCLES(20), .BLOCK_CYCLES(40),
    .CHIP_CYCLES(60)) dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .link_clk_in(link_clk_in), .lnk_cmd_valid_in(lnk_cmd_valid_in), .lnk_cmd_in(lnk_cmd_in),
    .lnk_cmd_ready_out(lnk_cmd_ready_out), .lnk_status_out(lnk_status_out),
    .wp_n_in(wp_n_in), .status_out(status_out), .array_req_out(array_req_out),
    .array_op_out(array_op_out), .cmd_reject_out(cmd_reject_out));
  link_host host_u (.link_clk_in(link_clk_in), .lnk_cmd_ready_in(lnk_cmd_ready_out),
    .lnk_cmd_valid_out(lnk_cmd_valid_in), .lnk_cmd_out(lnk_cmd_in));
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #15 link_clk_in = ~link_clk_in;
  end
  // count result pulses
  always @(negedge core_clk_in) begin
    if (array_req_out === 1'b1) n_req++;
    if (cmd_reject_out === 1'b1) n_rej++;
  end
  task automatic chk_word(input string nm, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_cnt(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      failures++;
      $display("FAIL %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt
  // one command through the host, then wait for the link to be free again
  task automatic cmd(input cmd_e op, input logic [1:0] s, input logic [7:0] d,
                     input logic [23:0] a);
    int n;
    host_u.send(link_cmd_s'{op, s, d, a});
    repeat (2) @(posedge link_clk_in);
    n = 0;
    while (lnk_cmd_ready_out !== 1'b1 && n < 50) begin
      @(posedge link_clk_in);
      n++;
    end
    if (n >= 50) failures++; // ready never came back
    repeat (4) @(posedge core_clk_in);
    #1;
  endtask : cmd
  task automatic idle;
    int n;
    n = 0;
    while (status_out[BUSY_BIT] !== 1'b0 && n < 3000) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 3000) failures++; // operation never ended
    #1;
  endtask : idle
  task automatic wrs(input logic [1:0] s, input logic [7:0] d);
    cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
    cmd(CMD_STATUS_WRITE, s, d, 24'h0);
    idle;
  endtask : wrs
  task automatic t_reset;
    chk_word("status", STATUS_RESET, status_out);
    chk_word("snapshot", STATUS_RESET, lnk_status_out);
  endtask : t_reset
  task automatic t_latch;
    int q = n_req;
    int r = n_rej;
    cmd(CMD_PAGE_WRITE, 2'h0, 8'h00, 24'h001000);
    chk_cnt("refused", r + 1, n_rej);
    chk_cnt("started", q, n_req);
    chk_word("status", STATUS_RESET, status_out);
    cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
    chk_word("latch", STATUS_RESET | 24'h000002, status_out);
    cmd(CMD_WRITE_DIS, 2'h0, 8'h00, 24'h0);
    chk_word("latch", STATUS_RESET, status_out);
  endtask : t_latch
  task automatic t_fields;
    wrs(SEL_BYTE3, 8'hff);
    chk_word("byte3", 24'he30000, status_out);
    wrs(SEL_BYTE3, 8'h20);
    wrs(SEL_BYTE2, 8'h86);
    chk_word("byte2", 24'h200200, status_out);
    cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
    cmd(CMD_STATUS_WRITE, SEL_BYTE1, 8'h7f, 24'h0);
    chk_word("busy", 24'h20027f, status_out);
    idle;
    chk_word("done", 24'h20027c, status_out);
    repeat (10) @(posedge link_clk_in);
    #1;
    chk_word("snapshot", 24'h20027c, lnk_status_out);
    wrs(SEL_BYTE2, 8'h00);
    wrs(SEL_BYTE1, 8'h00);
  endtask : t_fields
  task automatic t_region;
    logic [30:0] e;
    int q, r;
    logic [30:0] tb [10] = '{{2'h2, 5'h01, 24'hfc0000}, {2'h0, 5'h01, 24'hfbff00},
      {2'h2, 5'h09, 24'h03ff00}, {2'h0, 5'h09, 24'h040000}, {2'h2, 5'h11, 24'hfff000},
      {2'h0, 5'h11, 24'hffef00}, {2'h3, 5'h01, 24'hfbff00}, {2'h1, 5'h01, 24'hfc0000},
      {2'h3, 5'h19, 24'h001000}, {2'h1, 5'h19, 24'h000f00}};
    for (int i = 0; i < 10; i++) begin
      e = tb[i];
      wrs(SEL_BYTE2, {1'b0, e[29], 6'h00});
      wrs(SEL_BYTE1, {1'b0, e[28:24], 2'h0});
      q = n_req;
      r = n_rej;
      cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
      cmd(CMD_PAGE_WRITE, 2'h0, 8'h00, e[23:0]);
      chk_cnt("refused", r + e[30], n_rej);
      chk_cnt("started", q + !e[30], n_req);
      if (!e[30]) chk_word("target", e[23:0], array_op_out.addr);
      idle;
    end
  endtask : t_region
  task automatic t_erase;
    int q, r;
    logic [6:0] ct [6] = '{7'h40, 7'h09, 7'h67, 7'h21, 7'h58, 7'h38};
    wrs(SEL_BYTE2, 8'h00);
    wrs(SEL_BYTE1, 8'h24);
    r = n_rej;
    cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
    cmd(CMD_BLOCK_CLEAR, 2'h0, 8'h00, 24'h030000);
    chk_cnt("block", r + 1, n_rej);
    cmd(CMD_SECTOR_CLEAR, 2'h0, 8'h00, 24'h050123);
    chk_word("op", {20'h0, CMD_SECTOR_CLEAR}, {20'h0, array_op_out.op});
    chk_word("sector", 24'h050000, array_op_out.addr);
    idle;
    for (int i = 0; i < 6; i++) begin
      wrs(SEL_BYTE2, {1'b0, ct[i][5], 6'h00});
      wrs(SEL_BYTE1, {1'b0, ct[i][4:0], 2'h0});
      q = n_req;
      cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
      cmd(CMD_CHIP_CLEAR, 2'h0, 8'h00, 24'h0);
      chk_cnt("chip", q + ct[i][6], n_req);
      idle;
    end
  endtask : t_erase
  task automatic t_wp;
    int r;
    wrs(SEL_BYTE2, 8'h00);
    wrs(SEL_BYTE1, 8'h80);
    wp_n_in = 1'b0;
    repeat (4) @(posedge core_clk_in);
    r = n_rej;
    cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
    cmd(CMD_STATUS_WRITE, SEL_BYTE1, 8'h04, 24'h0);
    chk_cnt("locked", r + 1, n_rej);
    chk_word("locked", 24'h200082, status_out);
    wp_n_in = 1'b1;
    repeat (4) @(posedge core_clk_in);
    wrs(SEL_BYTE1, 8'h04);
    chk_word("unlocked", 24'h200004, status_out);
  endtask : t_wp
  task automatic t_pause;
    cmd(CMD_WRITE_EN, 2'h0, 8'h00, 24'h0);
    cmd(CMD_PAGE_WRITE, 2'h0, 8'h00, 24'h000100);
    cmd(CMD_PAUSE, 2'h0, 8'h00, 24'h0);
    chk_word("paused", 24'h200406, status_out);
    cmd(CMD_SOFT_RESET, 2'h0, 8'h00, 24'h0);
    chk_word("reset", 24'h200004, status_out);
  endtask : t_pause
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    failures = 0;
    compares = 0;
    n_req = 0;
    n_rej = 0;
    rst_n_in = 1'b0;
    wp_n_in = 1'b1;
    repeat (16) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (40) @(posedge core_clk_in);
    t_reset;
    t_latch;
    t_fields;
    t_region;
    t_erase;
    t_wp;
    t_pause;
    results;
  end
  // watchdog, roughly two and a half times the expected run
  initial begin
    #(4 * 95000);
    failures++;
    results;
  end
endmodule : test_flash_status_and_array_protect

// [verilog/flash_protect_pkg.sv]
package flash_protect_pkg;

  // address space and target spans
  localparam int ADDR_W = 24;
  localparam logic [23:0] PAGE_MASK = 24'h0000ff;
  localparam logic [23:0] SECTOR_MASK = 24'h000fff;
  localparam logic [23:0] BLOCK_MASK = 24'h00ffff;
  localparam logic [23:0] ADDR_TOP = 24'hffffff;
  localparam logic [23:0] FRACTION_UNIT = 24'h040000; // smallest fraction region
  localparam logic [23:0] SLICE_UNIT = 24'h001000; // smallest slice region
  localparam logic [23:0] SLICE_MAX = 24'h008000; // largest slice region

  // status word bit positions
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int REGION_LO_BIT = 2;
  localparam int MODE_LO_BIT = 7;
  localparam int MODE_HI_BIT = 8;
  localparam int QUAD_BIT = 9;
  localparam int PROG_PAUSE_BIT = 10;
  localparam int LOCK_LO_BIT = 11;
  localparam int INVERT_BIT = 14;
  localparam int ERASE_PAUSE_BIT = 15;
  localparam int LATENCY_LO_BIT = 16;
  localparam int DRIVE_LO_BIT = 21;
  localparam int PIN_FUNC_BIT = 23;

  // status-write byte selects
  localparam logic [1:0] SEL_BYTE1 = 2'h0;
  localparam logic [1:0] SEL_BYTE2 = 2'h1;
  localparam logic [1:0] SEL_BYTE3 = 2'h2;

  // values after power-up
  localparam logic [4:0] REGION_RESET = 5'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] LOCK_RESET = 3'h0;
  localparam logic [1:0] DRIVE_RESET = 2'h1;
  localparam logic [1:0] LATENCY_RESET = 2'h0;
  localparam logic [23:0] STATUS_RESET = 24'h200000;

  // internal operation times, and cycles at the core clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int STATUS_WRITE_NS = 2000;
  localparam int PAGE_WRITE_NS = 8000;
  localparam int SECTOR_CLEAR_NS = 40000;
  localparam int BLOCK_CLEAR_NS = 160000;
  localparam int CHIP_CLEAR_NS = 640000;
  localparam int STATUS_WRITE_CYC = STATUS_WRITE_NS / CLK_PERIOD_NS;
  localparam int PAGE_WRITE_CYC = PAGE_WRITE_NS / CLK_PERIOD_NS;
  localparam int SECTOR_CLEAR_CYC = SECTOR_CLEAR_NS / CLK_PERIOD_NS;
  localparam int BLOCK_CLEAR_CYC = BLOCK_CLEAR_NS / CLK_PERIOD_NS;
  localparam int CHIP_CLEAR_CYC = CHIP_CLEAR_NS / CLK_PERIOD_NS;

  // commands arriving from the serial controller
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_WRITE_EN = 4'h1,
    CMD_WRITE_DIS = 4'h2,
    CMD_STATUS_WRITE = 4'h3,
    CMD_PAGE_WRITE = 4'h4,
    CMD_SECTOR_CLEAR = 4'h5,
    CMD_BLOCK_CLEAR = 4'h6,
    CMD_CHIP_CLEAR = 4'h7,
    CMD_PAUSE = 4'h8,
    CMD_RESUME = 4'h9,
    CMD_SOFT_RESET = 4'ha
  } cmd_e;

  typedef struct packed {
    cmd_e op;
    logic [1:0] sel;
    logic [7:0] data;
    logic [23:0] addr;
  } link_cmd_s;

  typedef struct packed {
    cmd_e op;
    logic [23:0] addr;
  } array_req_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_PAUSED = 3'b100
  } op_state_e;

endpackage : flash_protect_pkg

// [verilog/flash_status_and_array_protect.sv]
`timescale 1ns/1ps
module flash_status_and_array_protect
  import flash_protect_pkg::*;
#(
  parameter int unsigned SECTOR_CYCLES = SECTOR_CLEAR_CYC, // sector erase time
  parameter int unsigned BLOCK_CYCLES = BLOCK_CLEAR_CYC, // block erase time
  parameter int unsigned CHIP_CYCLES = CHIP_CLEAR_CYC // chip erase time
) (
  input wire logic core_clk_in, // core clock
  input wire logic rst_n_in, // async reset, power-up
  input wire logic link_clk_in, // serial controller clock
  input wire logic lnk_cmd_valid_in, // command offered
  input wire link_cmd_s lnk_cmd_in, // command word
  output logic lnk_cmd_ready_out, // command can be taken
  output logic [23:0] lnk_status_out, // status snapshot, link side
  input wire logic wp_n_in, // write-protect pin
  output logic [23:0] status_out, // status word, core side
  output logic array_req_out, // one-cycle start to array
  output array_req_s array_op_out, // started operation
  output logic cmd_reject_out // one-cycle refusal pulse
);

  // ---------------- link domain ----------------
  logic lnk_pend_q, lnk_pend_d;
  logic lnk_ready_q, lnk_ready_d;
  logic lnk_req_tog_q, lnk_req_tog_d;
  link_cmd_s lnk_hold_q, lnk_hold_d;
  logic lnk_ack_s1_q, lnk_ack_s2_q, lnk_ack_seen_q, lnk_ack_seen_d;
  logic lnk_st_s1_q, lnk_st_s2_q, lnk_st_seen_q, lnk_st_seen_d;
  logic [23:0] lnk_status_q, lnk_status_d;

  // core domain state
  logic core_ack_tog_q;
  logic [23:0] core_st_hold_q;
  logic core_st_tog_q;

  // link side: hold one command until the core acknowledges it
  always_comb begin
    lnk_pend_d = lnk_pend_q;
    lnk_req_tog_d = lnk_req_tog_q;
    lnk_hold_d = lnk_hold_q;
    lnk_ack_seen_d = lnk_ack_seen_q;
    lnk_st_seen_d = lnk_st_seen_q;
    lnk_status_d = lnk_status_q;
    if (lnk_ack_s2_q != lnk_ack_seen_q) begin
      lnk_ack_seen_d = lnk_ack_s2_q;
      lnk_pend_d = 1'b0;
    end
    if (lnk_cmd_valid_in && lnk_ready_q) begin
      lnk_hold_d = lnk_cmd_in;
      lnk_req_tog_d = ~lnk_req_tog_q;
      lnk_pend_d = 1'b1;
    end
    if (lnk_st_s2_q != lnk_st_seen_q) begin
      lnk_st_seen_d = lnk_st_s2_q;
      lnk_status_d = core_st_hold_q; // stable while toggle unacknowledged
    end
    lnk_ready_d = ~lnk_pend_d;
  end

  // link side registers
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lnk_pend_q <= 1'b0;
      lnk_ready_q <= 1'b0;
      lnk_req_tog_q <= 1'b0;
      lnk_hold_q <= '0;
      lnk_ack_s1_q <= 1'b0;
      lnk_ack_s2_q <= 1'b0;
      lnk_ack_seen_q <= 1'b0;
      lnk_st_s1_q <= 1'b0;
      lnk_st_s2_q <= 1'b0;
      lnk_st_seen_q <= 1'b0;
      lnk_status_q <= STATUS_RESET;
    end else begin
      lnk_pend_q <= lnk_pend_d;
      lnk_ready_q <= lnk_ready_d;
      lnk_req_tog_q <= lnk_req_tog_d;
      lnk_hold_q <= lnk_hold_d;
      lnk_ack_s1_q <= core_ack_tog_q;
      lnk_ack_s2_q <= lnk_ack_s1_q;
      lnk_ack_seen_q <= lnk_ack_seen_d;
      lnk_st_s1_q <= core_st_tog_q;
      lnk_st_s2_q <= lnk_st_s1_q;
      lnk_st_seen_q <= lnk_st_seen_d;
      lnk_status_q <= lnk_status_d;
    end
  end

  assign lnk_cmd_ready_out = lnk_ready_q;
  assign lnk_status_out = lnk_status_q;

  // ---------------- core domain ----------------
  logic req_s1_q, req_s2_q, req_seen_q;
  logic wp_s1_q, wp_s2_q;
  logic st_ack_s1_q, st_ack_s2_q;
  logic [23:0] core_st_hold_d;
  logic core_st_tog_d;

  op_state_e state_q, state_d;
  cmd_e run_op_q, run_op_d;
  logic [23:0] count_q, count_d;
  logic latch_q, latch_d;
  logic erase_pause_q, erase_pause_d;
  logic prog_pause_q, prog_pause_d;
  logic [4:0] region_q, region_d;
  logic invert_q, invert_d;
  logic [1:0] mode_q, mode_d;
  logic [2:0] lock_q, lock_d;
  logic quad_q, quad_d;
  logic pin_func_q, pin_func_d;
  logic [1:0] drive_q, drive_d;
  logic [1:0] latency_q, latency_d;
  logic [23:0] status_q, status_d;
  logic array_req_q, array_req_d;
  array_req_s array_op_q, array_op_d;
  logic reject_q, reject_d;

  logic new_cmd;
  link_cmd_s cmd;
  logic idle;
  logic hw_locked;
  logic chip_ok;
  logic hit;
  logic [23:0] span;
  logic [23:0] first_addr;
  logic [23:0] last_addr;

  assign new_cmd = (req_s2_q != req_seen_q);
  assign cmd = lnk_hold_q; // held stable until the acknowledge returns
  assign idle = (state_q == ST_IDLE);

  // status writes barred by protect modes and the pin
  assign hw_locked = (mode_q == 2'h1 && !wp_s2_q) || mode_q[1];

  // chip erase allowed only when nothing is protected
  assign chip_ok = (region_q[2:0] == 3'h0 && !invert_q) ||
                   (region_q[2:0] == 3'h7 && invert_q);

  // target span of the command
  always_comb begin
    case (cmd.op)
      CMD_PAGE_WRITE: span = PAGE_MASK;
      CMD_SECTOR_CLEAR: span = SECTOR_MASK;
      CMD_BLOCK_CLEAR: span = BLOCK_MASK;
      default: span = 24'h000000;
    endcase
    first_addr = cmd.addr & ~span;
    last_addr = cmd.addr | span;
  end

  region_guard u_guard (
    .region_sel_in(region_q),
    .region_invert_in(invert_q),
    .first_addr_in(first_addr),
    .last_addr_in(last_addr),
    .hit_out(hit)
  );

  // command execution and internal operation timing
  always_comb begin
    state_d = state_q;
    run_op_d = run_op_q;
    count_d = count_q;
    latch_d = latch_q;
    erase_pause_d = erase_pause_q;
    prog_pause_d = prog_pause_q;
    region_d = region_q;
    invert_d = invert_q;
    mode_d = mode_q;
    lock_d = lock_q;
    quad_d = quad_q;
    pin_func_d = pin_func_q;
    drive_d = drive_q;
    latency_d = latency_q;
    array_req_d = 1'b0;
    array_op_d = array_op_q;
    reject_d = 1'b0;
    // running operation counts down, then drops busy and the latch
    if (state_q == ST_BUSY) begin
      if (count_q <= 24'h000001) begin
        state_d = ST_IDLE;
        count_d = 24'h000000;
        latch_d = 1'b0;
      end else begin
        count_d = count_q - 24'h000001;
      end
    end
    if (new_cmd) begin
      case (cmd.op)
        CMD_WRITE_EN: begin
          if (idle) latch_d = 1'b1;
          else reject_d = 1'b1;
        end
        CMD_WRITE_DIS: begin
          if (idle) latch_d = 1'b0;
          else reject_d = 1'b1;
        end
        CMD_STATUS_WRITE: begin
          if (idle && latch_q && !hw_locked) begin
            case (cmd.sel)
              SEL_BYTE1: begin
                mode_d[0] = cmd.data[MODE_LO_BIT];
                region_d = cmd.data[MODE_LO_BIT-1:REGION_LO_BIT];
              end
              SEL_BYTE2: begin
                invert_d = cmd.data[INVERT_BIT-8];
                lock_d = lock_q | cmd.data[INVERT_BIT-9:LOCK_LO_BIT-8]; // one-time set
                quad_d = cmd.data[QUAD_BIT-8];
                mode_d[1] = cmd.data[MODE_HI_BIT-8];
              end
              default: begin
                pin_func_d = cmd.data[PIN_FUNC_BIT-16];
                drive_d = cmd.data[PIN_FUNC_BIT-17:DRIVE_LO_BIT-16];
                latency_d = cmd.data[LATENCY_LO_BIT-15:LATENCY_LO_BIT-16];
              end
            endcase
            state_d = ST_BUSY;
            run_op_d = CMD_STATUS_WRITE;
            count_d = 24'(STATUS_WRITE_CYC);
          end else begin
            reject_d = 1'b1;
          end
        end
        CMD_PAGE_WRITE, CMD_SECTOR_CLEAR, CMD_BLOCK_CLEAR, CMD_CHIP_CLEAR: begin
          if (idle && latch_q && ((cmd.op == CMD_CHIP_CLEAR) ? chip_ok : !hit)) begin
            state_d = ST_BUSY;
            run_op_d = cmd.op;
            array_req_d = 1'b1;
            array_op_d.op = cmd.op;
            array_op_d.addr = first_addr;
            case (cmd.op)
              CMD_PAGE_WRITE: count_d = 24'(PAGE_WRITE_CYC);
              CMD_SECTOR_CLEAR: count_d = 24'(SECTOR_CYCLES);
              CMD_BLOCK_CLEAR: count_d = 24'(BLOCK_CYCLES);
              default: count_d = 24'(CHIP_CYCLES);
            endcase
          end else begin
            reject_d = 1'b1;
          end
        end
        CMD_PAUSE: begin
          if (state_q == ST_BUSY && run_op_q != CMD_STATUS_WRITE && count_q > 24'h000001) begin
            state_d = ST_PAUSED;
            count_d = count_q;
            if (run_op_q == CMD_PAGE_WRITE) prog_pause_d = 1'b1;
            else erase_pause_d = 1'b1;
          end else begin
            reject_d = 1'b1;
          end
        end
        CMD_RESUME: begin
          if (state_q == ST_PAUSED) begin
            state_d = ST_BUSY;
            prog_pause_d = 1'b0;
            erase_pause_d = 1'b0;
          end else begin
            reject_d = 1'b1;
          end
        end
        CMD_SOFT_RESET: begin
          if (state_q != ST_BUSY) begin
            state_d = ST_IDLE;
            count_d = 24'h000000;
            latch_d = 1'b0;
            prog_pause_d = 1'b0;
            erase_pause_d = 1'b0;
          end else begin
            reject_d = 1'b1;
          end
        end
        default: reject_d = 1'b1;
      endcase
    end
    // assemble the status word; reserved bits stay zero
    status_d = 24'h000000;
    status_d[BUSY_BIT] = (state_d == ST_BUSY);
    status_d[LATCH_BIT] = latch_d;
    status_d[MODE_LO_BIT-1:REGION_LO_BIT] = region_d;
    status_d[MODE_LO_BIT] = mode_d[0];
    status_d[MODE_HI_BIT] = mode_d[1];
    status_d[QUAD_BIT] = quad_d;
    status_d[PROG_PAUSE_BIT] = prog_pause_d;
    status_d[INVERT_BIT-1:LOCK_LO_BIT] = lock_d;
    status_d[INVERT_BIT] = invert_d;
    status_d[ERASE_PAUSE_BIT] = erase_pause_d;
    status_d[LATENCY_LO_BIT+1:LATENCY_LO_BIT] = latency_d;
    status_d[PIN_FUNC_BIT-1:DRIVE_LO_BIT] = drive_d;
    status_d[PIN_FUNC_BIT] = pin_func_d;
  end

  // publish a status snapshot to the link once the previous one is taken
  always_comb begin
    core_st_hold_d = core_st_hold_q;
    core_st_tog_d = core_st_tog_q;
    if (core_st_tog_q == st_ack_s2_q && status_q != core_st_hold_q) begin
      core_st_hold_d = status_q;
      core_st_tog_d = ~core_st_tog_q;
    end
  end

  // core registers; power-up reset doubles as the non-volatile defaults
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_seen_q <= 1'b0;
      core_ack_tog_q <= 1'b0;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
      st_ack_s1_q <= 1'b0;
      st_ack_s2_q <= 1'b0;
      core_st_hold_q <= STATUS_RESET;
      core_st_tog_q <= 1'b0;
      state_q <= ST_IDLE;
      run_op_q <= CMD_NOP;
      count_q <= 24'h000000;
      latch_q <= 1'b0;
      erase_pause_q <= 1'b0;
      prog_pause_q <= 1'b0;
      region_q <= REGION_RESET;
      invert_q <= 1'b0;
      mode_q <= MODE_RESET;
      lock_q <= LOCK_RESET;
      quad_q <= 1'b0;
      pin_func_q <= 1'b0;
      drive_q <= DRIVE_RESET;
      latency_q <= LATENCY_RESET;
      status_q <= STATUS_RESET;
      array_req_q <= 1'b0;
      array_op_q <= '0;
      reject_q <= 1'b0;
    end else begin
      req_s1_q <= lnk_req_tog_q;
      req_s2_q <= req_s1_q;
      req_seen_q <= req_s2_q;
      core_ack_tog_q <= req_s2_q; // acknowledge once executed
      wp_s1_q <= wp_n_in;
      wp_s2_q <= wp_s1_q;
      st_ack_s1_q <= lnk_st_seen_q;
      st_ack_s2_q <= st_ack_s1_q;
      core_st_hold_q <= core_st_hold_d;
      core_st_tog_q <= core_st_tog_d;
      state_q <= state_d;
      run_op_q <= run_op_d;
      count_q <= count_d;
      latch_q <= latch_d;
      erase_pause_q <= erase_pause_d;
      prog_pause_q <= prog_pause_d;
      region_q <= region_d;
      invert_q <= invert_d;
      mode_q <= mode_d;
      lock_q <= lock_d;
      quad_q <= quad_d;
      pin_func_q <= pin_func_d;
      drive_q <= drive_d;
      latency_q <= latency_d;
      status_q <= status_d;
      array_req_q <= array_req_d;
      array_op_q <= array_op_d;
      reject_q <= reject_d;
    end
  end

  assign status_out = status_q;
  assign array_req_out = array_req_q;
  assign array_op_out = array_op_q;
  assign cmd_reject_out = reject_q;

endmodule : flash_status_and_array_protect

// [verilog/region_guard.sv]
`timescale 1ns/1ps
module region_guard
  import flash_protect_pkg::*;
(
  input wire logic [4:0] region_sel_in, // block-protect code
  input wire logic region_invert_in, // complement bit
  input wire logic [23:0] first_addr_in, // first byte of target
  input wire logic [23:0] last_addr_in, // last byte of target
  output logic hit_out // target touches protected area
);

  // protected test for one address; regions always hug an end, so two ends suffice
  function automatic logic in_region(input logic [4:0] sel, input logic inv,
                                     input logic [23:0] a);
    logic [2:0] lo3;
    logic [23:0] size;
    logic [23:0] mask;
    logic base;
    lo3 = sel[2:0];
    if (!sel[4]) begin
      size = FRACTION_UNIT << (lo3 - 3'h1);
    end else if (lo3 >= 3'h4) begin
      size = SLICE_MAX;
    end else begin
      size = SLICE_UNIT << (lo3 - 3'h1);
    end
    mask = size - 24'h000001;
    if (lo3 == 3'h0) begin
      base = 1'b0;
    end else if (lo3 == 3'h7) begin
      base = 1'b1;
    end else if (!sel[3]) begin
      base = ((a | mask) == ADDR_TOP); // upper fraction or top slice
    end else begin
      base = ((a & ~mask) == 24'h000000); // lower fraction or bottom slice
    end
    return base ^ inv;
  endfunction : in_region

  // either end of the target inside the region rejects it
  always_comb begin
    hit_out = in_region(region_sel_in, region_invert_in, first_addr_in) |
              in_region(region_sel_in, region_invert_in, last_addr_in);
  end

endmodule : region_guard
